// *** src/pwm_pkg.sv ***
// Shared constants and types for the double-buffered PWM time base.
// Behaviour
// - Duty is duty high byte plus low field.
// - Duty writes never disturb the running period.
// - In PWM mode shadow loads only at period completion.
// - Shadow register ignores writes in PWM mode.
// - Shadow byte and hidden latch double-buffer duty.
// - Time base is count plus two lower bits.
// - At 1:1 low bits come from clock phase.
// - Output clears when time base matches shadow duty.
// - High time is duty times prescaled clock.
// - Duty ratio is duty over four times (limit+1).
// - Resolution follows period limit, ten bits at 255.
// - Duty beyond period leaves output unchanged.
// - Sleep freezes counting and holds the output.
// - Idle keeps clocking; other modes use selected clock.
// - Output frequency scales with the system clock.
// - Reset makes pins inputs, registers default.
// - Steering bits choose which four outputs carry PWM.
// - Rollover sets the match flag.
// - Waveform reaches pin only with direction cleared.
// - Prescaler divides by one, four or sixteen.
// - Period is (limit+1) times four times prescale.
// - Limit match clears count, sets output, loads duty.
// - Zero duty never sets the output.
// - Postscaler has no effect on the period.
package pwm_pkg;

  localparam int CLK_MHZ    = 40;
  localparam int UNITS      = 2;
  localparam int PINS       = 5;
  localparam int STEER_PINS = 4;
  localparam int UNIT2_PIN  = 4;
  localparam int DIV_W      = 6;

  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_ENABLES  = 8'h01;
  localparam logic [7:0] OFS_COUNT    = 8'h02;
  localparam logic [7:0] OFS_PERIOD   = 8'h03;
  localparam logic [7:0] OFS_TCTL     = 8'h04;
  localparam logic [7:0] OFS_DUTY_HI1 = 8'h05;
  localparam logic [7:0] OFS_SHADOW1  = 8'h06;
  localparam logic [7:0] OFS_UCTL1    = 8'h07;
  localparam logic [7:0] OFS_DUTY_HI2 = 8'h08;
  localparam logic [7:0] OFS_SHADOW2  = 8'h09;
  localparam logic [7:0] OFS_UCTL2    = 8'h0A;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h0B;
  localparam logic [7:0] OFS_RESTART  = 8'h0C;
  localparam logic [7:0] OFS_STEER    = 8'h0D;
  localparam logic [7:0] OFS_PIN_DIR  = 8'h0E;

  localparam int FLAG_MATCH_BIT = 1;
  localparam int TCTL_RUN_BIT   = 2;
  localparam int TCTL_PRE_LSB   = 0;
  localparam int UCTL_MODE_LSB  = 2;
  localparam int UCTL_LOW_LSB   = 4;

  localparam logic [7:0] TCTL_MASK   = 8'h7F;
  localparam logic [7:0] BASIC_MASK  = 8'h3F;
  localparam logic [7:0] STEER_MASK  = 8'h0F;
  localparam logic [7:0] DIR_MASK    = 8'h1F;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] STEER_RESET = 8'h01;
  localparam logic [1:0] PWM_MODE    = 2'h3;

  typedef enum logic [1:0] {
    PRE_DIV1  = 2'b00,
    PRE_DIV4  = 2'b01,
    PRE_DIV16 = 2'b10,
    PRE_ALT16 = 2'b11
  } prescale_t;

  localparam logic [DIV_W-1:0] TERM_DIV1  = 6'h03;
  localparam logic [DIV_W-1:0] TERM_DIV4  = 6'h0F;
  localparam logic [DIV_W-1:0] TERM_DIV16 = 6'h3F;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic       pwmOn;
    logic       freeze;
    logic [7:0] dutyHigh;
    logic [1:0] dutyLow;
  } chan_ctl_t;

endpackage

// *** src/pwm_prescaler.sv ***
// Clock divider that paces the time-base count and supplies its low bits.
`timescale 1ns/1ps
module pwm_prescaler
(
  input  logic                clk_sys,
  input  logic                rst,
  input  logic                run,
  input  logic                restart,
  input  pwm_pkg::prescale_t  sel,
  output logic                tick,
  output logic [1:0]          phase
);

  typedef struct packed {
    logic [pwm_pkg::DIV_W-1:0] cnt;
  } div_state_t;

  div_state_t                s;
  div_state_t                next_s;
  logic [pwm_pkg::DIV_W-1:0] term;

  always_comb
  begin
    next_s = s;
    case (sel)
      pwm_pkg::PRE_DIV1:
      begin
        term  = pwm_pkg::TERM_DIV1;
        phase = s.cnt[1:0];
      end
      pwm_pkg::PRE_DIV4:
      begin
        term  = pwm_pkg::TERM_DIV4;
        phase = s.cnt[3:2];
      end
      default:
      begin
        term  = pwm_pkg::TERM_DIV16;
        phase = s.cnt[5:4];
      end
    endcase
    tick = run && (s.cnt == term);
    if (restart)
      next_s.cnt = '0;
    else if (tick)
      next_s.cnt = '0;
    else if (run)
      next_s.cnt = s.cnt + 6'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

endmodule // pwm_prescaler

// *** src/pwm_channel.sv ***
// One PWM unit: duty double buffer, match compare and output level.
`timescale 1ns/1ps
module pwm_channel
(
  input  logic               clk_sys,
  input  logic               rst,
  input  pwm_pkg::chan_ctl_t ctl,
  input  logic               periodEnd,
  input  logic [9:0]         timeBase,
  input  logic               shadowWr,
  input  logic [7:0]         shadowData,
  output logic [7:0]         shadow,
  output logic               level
);

  typedef struct packed {
    logic [7:0] shadow;
    logic [1:0] lowLatch;
    logic       level;
  } chan_state_t;

  chan_state_t s;
  chan_state_t next_s;

  always_comb
  begin
    next_s = s;
    if (!ctl.pwmOn)
    begin
      next_s.level = 1'b0;
      if (shadowWr)
        next_s.shadow = shadowData;
    end
    else if (!ctl.freeze)
    begin
      if (periodEnd)
      begin
        next_s.shadow   = ctl.dutyHigh;
        next_s.lowLatch = ctl.dutyLow;
        next_s.level    = |{ctl.dutyHigh, ctl.dutyLow};
      end
      else if (timeBase == {s.shadow, s.lowLatch})
        next_s.level = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // The match masks the level in the very cycle that it occurs. The
  // registered level alone would only drop one clock later, which would
  // stretch every pulse by one clock and hide a match in the last step.
  assign shadow = s.shadow;
  assign level  = s.level && (timeBase != {s.shadow, s.lowLatch});

endmodule // pwm_channel

// *** src/pwm_timebase_top.sv ***
// Register file, time base and pin steering of the PWM generator.
`timescale 1ns/1ps
module pwm_timebase_top
(
  input  logic                clk_sys,
  input  logic                rst,
  input  pwm_pkg::reg_req_t   busReq,
  output logic [7:0]          regRdData,
  input  logic                sleepMode,
  input  logic                primaryIdleMode,
  output pwm_pkg::pin_drive_t pwmPins
);

  typedef struct packed {
    logic [7:0]             flags;
    logic [7:0]             enables;
    logic [7:0]             count;
    logic [7:0]             period;
    logic [7:0]             tctl;
    logic [1:0][7:0]        dutyHigh;
    logic [1:0][7:0]        uctl;
    logic [7:0]             shutdown;
    logic [7:0]             restart;
    logic [7:0]             steer;
    logic [7:0]             pinDir;
    logic [7:0]             rdData;
    pwm_pkg::pin_drive_t    pins;
  } top_state_t;

  top_state_t                   s;
  top_state_t                   next_s;
  logic                         tick;
  logic [1:0]                   phase;
  logic                         timerRun;
  logic                         divRestart;
  logic                         periodEnd;
  logic [9:0]                   timeBase;
  pwm_pkg::prescale_t           preSel;
  logic [pwm_pkg::UNITS-1:0]    level;
  logic [pwm_pkg::UNITS-1:0]    shadowWr;
  logic [pwm_pkg::UNITS-1:0][7:0] shadow;
  pwm_pkg::chan_ctl_t [pwm_pkg::UNITS-1:0] chanCtl;
  logic                         wrHit;
  logic [7:0]                   rdMux;
  logic [pwm_pkg::PINS-1:0]     pinLevel;

  // The primary-idle input needs no logic: the system clock keeps running
  // through it, so the unit carries on unchanged. Other low-power clocks
  // are chosen outside this block and simply arrive on clk_sys.
  // Every count here is in system clocks, so the output frequency moves
  // with clk_sys in proportion.

  assign timerRun = s.tctl[pwm_pkg::TCTL_RUN_BIT] && !sleepMode;
  assign preSel   = pwm_pkg::prescale_t'(s.tctl[pwm_pkg::TCTL_PRE_LSB +: 2]);

  // Writing the count or the timer control restarts the divider so a newly
  // loaded count always gets a whole prescaled step.
  assign wrHit = busReq.wr;
  assign divRestart = wrHit && ((busReq.addr == pwm_pkg::OFS_COUNT) ||
                                (busReq.addr == pwm_pkg::OFS_TCTL));

  pwm_prescaler u_prescaler
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (timerRun),
    .restart (divRestart),
    .sel     (preSel),
    .tick    (tick),
    .phase   (phase)
  );

  // The postscale field is stored and read back but never reaches the
  // period logic.
  assign periodEnd = tick && (s.count == s.period);
  assign timeBase  = {s.count, phase};

  genvar gi;
  generate
    for (gi = 0; gi < pwm_pkg::UNITS; gi++)
    begin : g_unit
      assign chanCtl[gi].pwmOn =
        (s.uctl[gi][pwm_pkg::UCTL_MODE_LSB +: 2] == pwm_pkg::PWM_MODE);
      assign chanCtl[gi].freeze   = sleepMode;
      assign chanCtl[gi].dutyHigh = s.dutyHigh[gi];
      assign chanCtl[gi].dutyLow  =
        s.uctl[gi][pwm_pkg::UCTL_LOW_LSB +: 2];
      assign shadowWr[gi] = wrHit && (busReq.addr ==
        ((gi == 0) ? pwm_pkg::OFS_SHADOW1 : pwm_pkg::OFS_SHADOW2));

      pwm_channel u_channel
      (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .ctl        (chanCtl[gi]),
        .periodEnd  (periodEnd),
        .timeBase   (timeBase),
        .shadowWr   (shadowWr[gi]),
        .shadowData (busReq.wrData),
        .shadow     (shadow[gi]),
        .level      (level[gi])
      );
    end
  endgenerate

  // The first unit feeds the four steered pins, the second its own pin.
  always_comb
  begin
    pinLevel = '0;
    for (int p = 0; p < pwm_pkg::STEER_PINS; p++)
    begin
      pinLevel[p] = level[0] && s.steer[p];
    end
    pinLevel[pwm_pkg::UNIT2_PIN] = level[1];
  end

  always_comb
  begin
    case (busReq.addr)
      pwm_pkg::OFS_FLAGS:
        rdMux = s.flags;
      pwm_pkg::OFS_ENABLES:
        rdMux = s.enables;
      pwm_pkg::OFS_COUNT:
        rdMux = s.count;
      pwm_pkg::OFS_PERIOD:
        rdMux = s.period;
      pwm_pkg::OFS_TCTL:
        rdMux = s.tctl & pwm_pkg::TCTL_MASK;
      pwm_pkg::OFS_DUTY_HI1:
        rdMux = s.dutyHigh[0];
      pwm_pkg::OFS_SHADOW1:
        rdMux = shadow[0];
      pwm_pkg::OFS_UCTL1:
        rdMux = s.uctl[0];
      pwm_pkg::OFS_DUTY_HI2:
        rdMux = s.dutyHigh[1];
      pwm_pkg::OFS_SHADOW2:
        rdMux = shadow[1];
      pwm_pkg::OFS_UCTL2:
        rdMux = s.uctl[1] & pwm_pkg::BASIC_MASK;
      pwm_pkg::OFS_SHUTDOWN:
        rdMux = s.shutdown;
      pwm_pkg::OFS_RESTART:
        rdMux = s.restart;
      pwm_pkg::OFS_STEER:
        rdMux = s.steer & pwm_pkg::STEER_MASK;
      pwm_pkg::OFS_PIN_DIR:
        rdMux = s.pinDir & pwm_pkg::DIR_MASK;
      default:
        rdMux = pwm_pkg::ZERO_BYTE;
    endcase
  end

  always_comb
  begin
    next_s = s;

    if (tick)
    begin
      if (periodEnd)
        next_s.count = pwm_pkg::ZERO_BYTE;
      else
        next_s.count = s.count + 8'h01;
    end

    // Duty registers are plain storage; the running period only ever
    // sees the shadow copies, so these writes cannot glitch it.
    if (wrHit)
    begin
      case (busReq.addr)
        pwm_pkg::OFS_FLAGS:
          next_s.flags = busReq.wrData;
        pwm_pkg::OFS_ENABLES:
          next_s.enables = busReq.wrData;
        pwm_pkg::OFS_COUNT:
          next_s.count = busReq.wrData;
        pwm_pkg::OFS_PERIOD:
          next_s.period = busReq.wrData;
        pwm_pkg::OFS_TCTL:
          next_s.tctl = busReq.wrData & pwm_pkg::TCTL_MASK;
        pwm_pkg::OFS_DUTY_HI1:
          next_s.dutyHigh[0] = busReq.wrData;
        pwm_pkg::OFS_UCTL1:
          next_s.uctl[0] = busReq.wrData;
        pwm_pkg::OFS_DUTY_HI2:
          next_s.dutyHigh[1] = busReq.wrData;
        pwm_pkg::OFS_UCTL2:
          next_s.uctl[1] = busReq.wrData & pwm_pkg::BASIC_MASK;
        pwm_pkg::OFS_SHUTDOWN:
          next_s.shutdown = busReq.wrData;
        pwm_pkg::OFS_RESTART:
          next_s.restart = busReq.wrData;
        pwm_pkg::OFS_STEER:
          next_s.steer = busReq.wrData & pwm_pkg::STEER_MASK;
        pwm_pkg::OFS_PIN_DIR:
          next_s.pinDir = busReq.wrData | ~pwm_pkg::DIR_MASK;
        default:
          next_s.rdData = s.rdData;
      endcase
    end

    // A rollover in the same cycle as a software clear still leaves the
    // flag set, so software never misses a period start.
    if (periodEnd)
      next_s.flags[pwm_pkg::FLAG_MATCH_BIT] = 1'b1;

    if (busReq.rd)
      next_s.rdData = rdMux;
    else
      next_s.rdData = pwm_pkg::ZERO_BYTE;

    // Pins drive only with their direction bit cleared; a pin that is not
    // driven also shows a low output value.
    for (int p = 0; p < pwm_pkg::PINS; p++)
    begin
      next_s.pins.oe[p]  = !s.pinDir[p];
      next_s.pins.out[p] = pinLevel[p] && !s.pinDir[p];
    end
    if (sleepMode)
      next_s.pins = s.pins;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s        <= '0;
      s.pinDir <= pwm_pkg::DIR_RESET;
      s.steer  <= pwm_pkg::STEER_RESET;
    end
    else
      s <= next_s;
  end

  assign regRdData = s.rdData;
  assign pwmPins   = s.pins;

endmodule // pwm_timebase_top

// *** test/pwm_timebase_monitor.sv ***
// Port checker for the PWM time base top, bound at the foot of this file.
`timescale 1ns/1ps
module pwm_timebase_monitor
(
  input logic                clk_sys,
  input logic                rst,
  input pwm_pkg::reg_req_t   busReq,
  input logic [7:0]          regRdData,
  input logic                sleepMode,
  input logic                primaryIdleMode,
  input pwm_pkg::pin_drive_t pwmPins
);
  logic [15:0][7:0] mirror;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Copies of what software wrote; hardware-set bits are not mirrored.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mirror <= '0;
      mirror[pwm_pkg::OFS_STEER[3:0]] <= pwm_pkg::STEER_RESET;
      mirror[pwm_pkg::OFS_PIN_DIR[3:0]] <= pwm_pkg::DIR_RESET;
    end
    else if (busReq.wr && busReq.addr[7:4] == 4'h0)
    begin
      mirror[busReq.addr[3:0]] <= busReq.wrData;
    end
  end

  sequence readOf(logic [7:0] a);
    busReq.rd && busReq.addr == a;
  endsequence

  property readsBack(logic [7:0] a, logic [7:0] m);
    readOf(a) |=> regRdData == ($past(mirror[a[3:0]]) & m);
  endproperty

  reset_quiet_a:
    assert property ($past(rst) |-> pwmPins == '0)
    else $error("pins not quiet after reset");
  sleep_freeze_a:
    assert property (sleepMode && !busReq.wr |=> $stable(pwmPins))
    else $error("pins moved during sleep");
  dir_gates_a:
    assert property (pwmPins.oe == ~$past(mirror[14][4:0]))
    else $error("pin enable does not follow direction");
  period_back_a:
    assert property (readsBack(pwm_pkg::OFS_PERIOD, 8'hFF))
    else $error("period limit read back wrong");
  duty_back_a:
    assert property (readsBack(pwm_pkg::OFS_DUTY_HI1, 8'hFF))
    else $error("duty high read back wrong");
  unit_back_a:
    assert property (readsBack(pwm_pkg::OFS_UCTL1, 8'hFF))
    else $error("unit control read back wrong");
  steer_back_a:
    assert property (readsBack(pwm_pkg::OFS_STEER, pwm_pkg::STEER_MASK))
    else $error("steering read back wrong");
  dir_back_a:
    assert property (readsBack(pwm_pkg::OFS_PIN_DIR, pwm_pkg::DIR_MASK))
    else $error("pin direction read back wrong");
endmodule // pwm_timebase_monitor

bind pwm_timebase_top pwm_timebase_monitor pwm_timebase_monitor_inst
(
  .clk_sys         (clk_sys),
  .rst             (rst),
  .busReq          (busReq),
  .regRdData       (regRdData),
  .sleepMode       (sleepMode),
  .primaryIdleMode (primaryIdleMode),
  .pwmPins         (pwmPins)
);

// *** test/double_buffered_pwm_timebase_tb_top.sv ***
// Bench for the PWM time base: register map, timing, buffering, sleep.
`timescale 1ns/1ps
module double_buffered_pwm_timebase_tb_top;
  logic                clk_sys;
  logic                rst;
  pwm_pkg::reg_req_t   busReq;
  logic [7:0]          regRdData;
  logic                sleepMode;
  logic                primaryIdleMode;
  pwm_pkg::pin_drive_t pwmPins;
  logic [7:0]          got;
  logic [7:0]          frozen;
  logic [4:0]          held;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  int                  hi;
  int                  lo;
  int                  n;

  pwm_timebase_top pwm_timebase_top_inst
  (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .busReq          (busReq),
    .regRdData       (regRdData),
    .sleepMode       (sleepMode),
    .primaryIdleMode (primaryIdleMode),
    .pwmPins         (pwmPins)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole run needs under 3000 cycles; reaching 20000 means a hang.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w);
    @(posedge clk_sys);
    busReq <= '{addr: a, wrData: d, wr: w, rd: !w};
    @(posedge clk_sys);
    busReq <= '0;
    #1 got = regRdData;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    access(a, 8'h00, 1'b0);
    check($sformatf("register %h", a), {8'h00, exp}, {8'h00, got});
  endtask

  task automatic runWhile(input int pin, input logic lvl, input int lim,
                          output int len);
    len = 0;
    while (pwmPins.out[pin] === lvl && len < lim)
    begin
      @(negedge clk_sys);
      len++;
    end
  endtask

  // Skips the partial period in progress, then times one whole period.
  task automatic measure(input int pin);
    runWhile(pin, 1'b1, 3000, n);
    runWhile(pin, 1'b0, 3000, n);
    runWhile(pin, 1'b1, 3000, hi);
    runWhile(pin, 1'b0, 3000, lo);
  endtask

  initial
  begin
    rst = 1'b1;
    busReq = '0;
    sleepMode = 1'b0;
    primaryIdleMode = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("pins after reset", 16'h0000, {6'h00, pwmPins});
    for (int a = 0; a < 17; a++)
      rd(8'(a), a == 14 ? pwm_pkg::DIR_RESET & pwm_pkg::DIR_MASK :
                a == 13 ? pwm_pkg::STEER_RESET : 8'h00);
    wr(pwm_pkg::OFS_PIN_DIR, 8'hFF);
    wr(pwm_pkg::OFS_STEER, 8'h01);
    wr(pwm_pkg::OFS_PERIOD, 8'h03);
    wr(pwm_pkg::OFS_UCTL1, 8'h3C);
    wr(pwm_pkg::OFS_DUTY_HI1, 8'h02);
    wr(pwm_pkg::OFS_UCTL2, 8'h2C);
    wr(pwm_pkg::OFS_DUTY_HI2, 8'h01);
    wr(pwm_pkg::OFS_FLAGS, 8'h00);
    rd(pwm_pkg::OFS_FLAGS, 8'h00);
    rd(pwm_pkg::OFS_COUNT, 8'h00);
    wr(pwm_pkg::OFS_TCTL, 8'h04);
    got = 8'h00;
    n = 0;
    while (got[pwm_pkg::FLAG_MATCH_BIT] !== 1'b1 && n < 50)
    begin
      access(pwm_pkg::OFS_FLAGS, 8'h00, 1'b0);
      n++;
    end
    check("match flag", 16'h0001, {15'h0, got[1]});
    wr(pwm_pkg::OFS_PIN_DIR, 8'h00);
    for (int p = 0; p < 3; p++)
    begin
      wr(pwm_pkg::OFS_TCTL, 8'h04 | 8'(p));
      measure(0);
      check("high time", 16'(11 << 2 * p), 16'(hi));
      check("period", 16'(16 << 2 * p), 16'(hi + lo));
    end
    measure(4);
    check("second unit high", 16'h0060, 16'(hi));
    wr(pwm_pkg::OFS_TCTL, 8'h05);
    measure(0);
    fork
      runWhile(0, 1'b1, 3000, hi);
      begin
        wr(pwm_pkg::OFS_DUTY_HI1, 8'h01);
        wr(pwm_pkg::OFS_UCTL1, 8'h1C);
      end
    join
    runWhile(0, 1'b0, 3000, lo);
    check("high before reload", 16'h002C, 16'(hi));
    runWhile(0, 1'b1, 3000, hi);
    check("high after reload", 16'h0014, 16'(hi));
    wr(pwm_pkg::OFS_DUTY_HI1, 8'h00);
    wr(pwm_pkg::OFS_UCTL1, 8'h0C);
    repeat (130) @(negedge clk_sys);
    runWhile(0, 1'b0, 130, n);
    check("zero duty level", 16'h0082, 16'(n));
    wr(pwm_pkg::OFS_DUTY_HI1, 8'hFF);
    wr(pwm_pkg::OFS_UCTL1, 8'h3C);
    repeat (130) @(negedge clk_sys);
    runWhile(0, 1'b1, 130, n);
    check("overlong duty level", 16'h0082, 16'(n));
    rd(pwm_pkg::OFS_SHADOW1, 8'hFF);
    wr(pwm_pkg::OFS_SHADOW1, 8'h5A);
    rd(pwm_pkg::OFS_SHADOW1, 8'hFF);
    rd(pwm_pkg::OFS_SHADOW2, 8'h01);
    wr(pwm_pkg::OFS_DUTY_HI1, 8'h02);
    wr(pwm_pkg::OFS_STEER, 8'h04);
    wr(pwm_pkg::OFS_PIN_DIR, 8'h1B);
    measure(2);
    check("steered high", 16'h002C, 16'(hi));
    runWhile(0, 1'b0, 300, n);
    check("unsteered level", 16'h012C, 16'(n));
    check("pin enables", 16'h0004, {11'h0, pwmPins.oe});
    @(posedge clk_sys);
    primaryIdleMode <= 1'b1;
    measure(2);
    check("idle period", 16'h0040, 16'(hi + lo));
    @(posedge clk_sys);
    primaryIdleMode <= 1'b0;
    sleepMode <= 1'b1;
    access(pwm_pkg::OFS_COUNT, 8'h00, 1'b0);
    frozen = got;
    held = pwmPins.out;
    repeat (40) @(posedge clk_sys);
    rd(pwm_pkg::OFS_COUNT, frozen);
    check("pins in sleep", {11'h0, held}, {11'h0, pwmPins.out});
    @(posedge clk_sys);
    sleepMode <= 1'b0;
    wr(pwm_pkg::OFS_TCTL, 8'h7D);
    measure(2);
    check("period after wake", 16'h0040, 16'(hi + lo));
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(pwm_pkg::OFS_PERIOD, 8'h00);
    check("pins after reset", 16'h0000, {6'h00, pwmPins});
    finish_test();
  end
endmodule // double_buffered_pwm_timebase_tb_top
